/* File: src/aspf_pkg.sv */
// Constants, register map and packet layout for the transmit packet framer.
// Assumes a host that programs the framer over AXI4-Lite and a link transmit FIFO write port.
package aspf_pkg;
	// ------------------------------------------------------------
	// Register offsets (byte addresses).
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CFG = 8'h08;
	localparam logic [7:0] REG_DEST = 8'h0C;
	localparam logic [7:0] REG_OFFLO = 8'h10;
	localparam logic [7:0] REG_LEN = 8'h14;
	localparam logic [7:0] REG_QDATA = 8'h18;
	localparam logic [7:0] REG_STREAM = 8'h1C;
	localparam logic [7:0] REG_BUF = 8'h40;
	localparam int BUF_WORDS = 16;
	localparam logic [15:0] MAX_LEN = 16'h0040;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------
	// Transaction codes and formats.
	// ------------------------------------------------------------
	localparam logic [3:0] TC_WRQ = 4'h0;
	localparam logic [3:0] TC_WRB = 4'h1;
	localparam logic [3:0] TC_WRSP = 4'h2;
	localparam logic [3:0] TC_RDQ = 4'h4;
	localparam logic [3:0] TC_RDB = 4'h5;
	localparam logic [3:0] TC_RRSPQ = 4'h6;
	localparam logic [3:0] TC_RRSPB = 4'h7;
	localparam logic [3:0] TC_LOCK = 4'h9;
	localparam logic [3:0] TC_STREAM = 4'hA;
	localparam logic [3:0] TC_LRSP = 4'hB;
	localparam logic [3:0] TC_UNFMT = 4'hE;
	localparam logic [2:0] FMT_BAD = 3'h0;
	localparam logic [2:0] FMT_NODATA = 3'h1;
	localparam logic [2:0] FMT_QUAD = 3'h2;
	localparam logic [2:0] FMT_BLOCK = 3'h3;
	localparam logic [2:0] FMT_STREAM = 3'h4;
	localparam logic [2:0] FMT_UNFMT = 3'h5;
	localparam logic [5:0] NODATA_QUADS = 6'h03;
	localparam logic [5:0] QUAD_QUADS = 6'h04;
	localparam logic [5:0] BLOCK_HDR = 6'h04;
	localparam logic [5:0] STREAM_HDR = 6'h02;
	localparam logic [5:0] UNFMT_HDR = 6'h01;
	localparam logic [1:0] RETRY_X = 2'h1;
	localparam logic [1:0] SPD_UNDEF = 2'h3;
	localparam logic [3:0] PRIO_MAX_RESP = 4'h1;
	// ------------------------------------------------------------
	// CFG register fields.
	// ------------------------------------------------------------
	localparam int CFG_TC = 0;
	localparam int CFG_SPD = 4;
	localparam int CFG_PRIO = 8;
	localparam int CFG_TL = 16;
	localparam int CFG_RC = 24;
	// Control quadlet: zeros, spd[17:16], tLabel[15:10], rt[9:8], tCode[7:4], priority[3:0].
	localparam int Q0_RT = 8;
endpackage : aspf_pkg

/* File: src/aspf_host_framer.sv */
// Host-side framer: software fills header registers and a data buffer, then the
// framer writes the packet quadlet by quadlet into the link transmit FIFO.
// Assumes the FIFO takes a quadlet on each clock edge where txValid and txReady are high.
`timescale 1ns/1ps
module aspf_host_framer
	import aspf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] txData,
	output logic txValid,
	output logic txLast,
	input wire logic txReady
);
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} aspf_state_t;
	typedef struct packed {
		aspf_state_t st;
		logic [31:0] cfg;
		logic [31:0] dest;
		logic [31:0] offLo;
		logic [31:0] lenExt;
		logic [31:0] qData;
		logic [31:0] strm;
		logic [BUF_WORDS-1:0][31:0] dataBuf;
		logic [5:0] idx;
		logic [5:0] total;
		logic [31:0] txData;
		logic txValid;
		logic txLast;
		logic done;
		logic err;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} aspf_regs_t;
	aspf_regs_t s_q, s_d;

	// ------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------
	function automatic logic [2:0] fmtOf(input logic [3:0] tc);
		case (tc)
			TC_RDQ, TC_WRSP: fmtOf = FMT_NODATA;
			TC_WRQ, TC_RRSPQ: fmtOf = FMT_QUAD;
			TC_RDB, TC_WRB, TC_RRSPB, TC_LOCK, TC_LRSP: fmtOf = FMT_BLOCK;
			TC_STREAM: fmtOf = FMT_STREAM;
			TC_UNFMT: fmtOf = FMT_UNFMT;
			default: fmtOf = FMT_BAD;
		endcase
	endfunction : fmtOf

	function automatic logic isResp(input logic [3:0] tc);
		isResp = (tc == TC_WRSP) || (tc == TC_RRSPQ) || (tc == TC_RRSPB) || (tc == TC_LRSP);
	endfunction : isResp

	function automatic logic [5:0] dataQuads(input aspf_regs_t s);
		logic [16:0] rounded;
		rounded = {1'b0, s.lenExt[15:0]} + 17'h00003;
		// A block read request only asks for data; it carries none.
		if (s.cfg[CFG_TC +: 4] == TC_RDB) begin
			dataQuads = 6'h00;
		end else begin
			dataQuads = rounded[7:2];
		end
	endfunction : dataQuads

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		for (int b = 0; b < 4; b++) begin
			mergeBytes[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction : mergeBytes

	// Builds quadlet i of the packet from the programmed fields.
	function automatic logic [31:0] quadAt(input aspf_regs_t s, input logic [5:0] i);
		logic [3:0] tc;
		logic [2:0] fm;
		logic [5:0] hdr;
		logic [5:0] di;
		logic [31:0] w;
		logic [1:0] tail;
		tc = s.cfg[CFG_TC +: 4];
		fm = fmtOf(tc);
		hdr = (fm == FMT_STREAM) ? STREAM_HDR : (fm == FMT_UNFMT) ? UNFMT_HDR : BLOCK_HDR;
		di = i - hdr;
		w = s.dataBuf[di[3:0]];
		tail = s.lenExt[1:0];
		quadAt = 32'h00000000;
		if (i == 6'h00) begin
			// Retry code forced, reserved bits zero.
			quadAt = {14'h0000, s.cfg[CFG_SPD +: 2], s.cfg[CFG_TL +: 6], RETRY_X, tc, s.cfg[CFG_PRIO +: 4]};
		end else if (i >= hdr && (fm == FMT_BLOCK || fm == FMT_STREAM || fm == FMT_UNFMT)) begin
			if (di == dataQuads(s) - 6'h01 && tail != 2'h0) begin
				case (tail)
					2'h1: quadAt = {w[31:24], 24'h000000};
					2'h2: quadAt = {w[31:16], 16'h0000};
					default: quadAt = {w[31:8], 8'h00};
				endcase
			end else begin
				quadAt = w;
			end
		end else if (fm == FMT_STREAM) begin
			quadAt = {s.lenExt[15:0], s.strm[1:0], s.strm[13:8], tc, s.strm[19:16]};
		end else if (i == 6'h01) begin
			quadAt = isResp(tc) ? {s.dest[31:16], s.cfg[CFG_RC +: 4], 12'h000} : s.dest;
		end else if (i == 6'h02) begin
			quadAt = isResp(tc) ? 32'h00000000 : s.offLo;
		end else if (fm == FMT_QUAD) begin
			quadAt = s.qData;
		end else begin
			quadAt = {s.lenExt[15:0], (tc == TC_LOCK || tc == TC_LRSP) ? s.lenExt[31:16] : 16'h0000};
		end
	endfunction : quadAt

	// ------------------------------------------------------------
	// Next state.
	// ------------------------------------------------------------
	logic [3:0] curTc;
	logic [2:0] curFmt;
	logic [5:0] curTotal;
	logic badReq;
	assign curTc = s_q.cfg[CFG_TC +: 4];
	assign curFmt = fmtOf(curTc);

	always_comb begin
		s_d = s_q;
		case (curFmt)
			FMT_NODATA: curTotal = NODATA_QUADS;
			FMT_QUAD: curTotal = QUAD_QUADS;
			FMT_BLOCK: curTotal = BLOCK_HDR + dataQuads(s_q);
			FMT_STREAM: curTotal = STREAM_HDR + dataQuads(s_q);
			default: curTotal = UNFMT_HDR + dataQuads(s_q);
		endcase
		// Illegal requests never reach the FIFO; the error flag reports them instead.
		badReq = (curFmt == FMT_BAD) || (s_q.cfg[CFG_SPD +: 2] == SPD_UNDEF)
			|| (s_q.lenExt[15:0] > MAX_LEN && curTc != TC_RDB)
			|| (isResp(curTc) && s_q.cfg[CFG_PRIO +: 4] > PRIO_MAX_RESP)
			|| (isResp(curTc) && !(s_q.cfg[CFG_RC +: 4] == 4'h0 || (s_q.cfg[CFG_RC +: 4] >= 4'h4
			&& s_q.cfg[CFG_RC +: 4] <= 4'h7)));
		s_d.awready = 1'b0;
		s_d.wready = 1'b0;
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (!s_q.bvalid && !s_q.awready && awvalid && wvalid) begin
			s_d.awready = 1'b1;
			s_d.wready = 1'b1;
		end
		if (s_q.awready) begin
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			// Header and buffer are frozen while a packet is leaving so it cannot tear.
			if (awaddr >= REG_BUF) begin
				if (s_q.st == ST_IDLE) begin
					s_d.dataBuf[awaddr[5:2]] = mergeBytes(s_q.dataBuf[awaddr[5:2]], wdata, wstrb);
				end
			end else begin
				case (awaddr)
					REG_CTRL: begin
						if (wdata[0] && wstrb[0] && s_q.st == ST_IDLE) begin
							s_d.done = 1'b0;
							s_d.err = badReq;
							if (!badReq) begin
								s_d.st = ST_SEND;
								s_d.idx = 6'h00;
								s_d.total = curTotal;
								s_d.txData = quadAt(s_q, 6'h00);
								s_d.txValid = 1'b1;
								// A one-quadlet packet marks its control quadlet as the last one.
								s_d.txLast = (curTotal == 6'h01);
							end
						end
					end
					REG_STATUS: s_d.bresp = RESP_OKAY;
					REG_CFG: s_d.cfg = (s_q.st == ST_IDLE) ? mergeBytes(s_q.cfg, wdata, wstrb) : s_q.cfg;
					REG_DEST: s_d.dest = (s_q.st == ST_IDLE) ? mergeBytes(s_q.dest, wdata, wstrb) : s_q.dest;
					REG_OFFLO: s_d.offLo = (s_q.st == ST_IDLE) ? mergeBytes(s_q.offLo, wdata, wstrb) : s_q.offLo;
					REG_LEN: s_d.lenExt = (s_q.st == ST_IDLE) ? mergeBytes(s_q.lenExt, wdata, wstrb) : s_q.lenExt;
					REG_QDATA: s_d.qData = (s_q.st == ST_IDLE) ? mergeBytes(s_q.qData, wdata, wstrb) : s_q.qData;
					REG_STREAM: s_d.strm = (s_q.st == ST_IDLE) ? mergeBytes(s_q.strm, wdata, wstrb) : s_q.strm;
					default: s_d.bresp = RESP_SLVERR;
				endcase
			end
		end
		s_d.arready = 1'b0;
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		if (!s_q.rvalid && !s_q.arready && arvalid) begin
			s_d.arready = 1'b1;
		end
		if (s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			if (araddr >= REG_BUF) begin
				s_d.rdata = s_q.dataBuf[araddr[5:2]];
			end else begin
				case (araddr)
					REG_CTRL: s_d.rdata = 32'h00000000;
					REG_STATUS: s_d.rdata = {18'h00000, s_q.idx, 5'h00, s_q.err, s_q.done, s_q.st == ST_SEND};
					REG_CFG: s_d.rdata = s_q.cfg;
					REG_DEST: s_d.rdata = s_q.dest;
					REG_OFFLO: s_d.rdata = s_q.offLo;
					REG_LEN: s_d.rdata = s_q.lenExt;
					REG_QDATA: s_d.rdata = s_q.qData;
					REG_STREAM: s_d.rdata = s_q.strm;
					default: begin
						s_d.rdata = 32'h00000000;
						s_d.rresp = RESP_SLVERR;
					end
				endcase
			end
		end
		case (s_q.st)
			ST_IDLE: s_d.txValid = s_d.txValid;
			ST_SEND: begin
				if (txReady) begin
					if (s_q.txLast || s_q.idx + 6'h01 == s_q.total) begin
						s_d.st = ST_IDLE;
						s_d.txValid = 1'b0;
						s_d.txLast = 1'b0;
						s_d.done = 1'b1;
					end else begin
						s_d.idx = s_q.idx + 6'h01;
						s_d.txData = quadAt(s_q, s_q.idx + 6'h01);
						s_d.txLast = (s_q.idx + 6'h02 == s_q.total);
					end
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign awready = s_q.awready;
	assign wready = s_q.wready;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign arready = s_q.arready;
	assign rvalid = s_q.rvalid;
	assign rresp = s_q.rresp;
	assign rdata = s_q.rdata;
	assign txData = s_q.txData;
	assign txValid = s_q.txValid;
	assign txLast = s_q.txLast;

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	AST_RT_FIXED: assert property (txValid && s_q.idx == 6'h00 |-> txData[Q0_RT +: 2] == RETRY_X)
		else $error("control quadlet retry code is not retry-X");
	AST_RESV_ZERO: assert property (txValid && s_q.idx == 6'h00 |-> txData[31:18] == 14'h0000)
		else $error("reserved control bits not zero");
	AST_HOLD: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(s_q.idx))
		else $error("transmit quadlet changed before it was taken");
	AST_NODATA_LEN: assert property (txValid && txLast && curFmt == FMT_NODATA |-> s_q.idx == 6'h02)
		else $error("no-data packet not three quadlets long");
	AST_PRIO_RESP: assert property (txValid && s_q.idx == 6'h00 && isResp(curTc) |-> txData[3:0] <= PRIO_MAX_RESP)
		else $error("response priority out of range");
	AST_RCODE: assert property (txValid && s_q.idx == 6'h01 && isResp(curTc) && curFmt != FMT_STREAM
		|-> txData[15:12] inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h7})
		else $error("reserved response code sent");
	AST_BLOCK_LEN: assert property (txValid && s_q.idx == 6'h03 && curFmt == FMT_BLOCK
		|-> txData[31:16] == s_q.lenExt[15:0])
		else $error("block length quadlet wrong");
	AST_PAD: assert property (txValid && txLast && s_q.idx >= BLOCK_HDR && curFmt == FMT_BLOCK
		&& s_q.lenExt[1:0] == 2'h1 |-> txData[23:0] == 24'h000000)
		else $error("tail padding bytes not zero");
	AST_ZERO_DATA: assert property (txValid && txLast && curFmt == FMT_BLOCK && s_q.lenExt[15:0] == 16'h0000
		|-> s_q.idx == 6'h03)
		else $error("data quadlets sent with zero length");
	AST_LAST_MARK: assert property (txValid && txReady && !txLast |=> txValid)
		else $error("packet ended without a last quadlet mark");
	AST_BRESP: assert property (s_q.awready |=> bvalid)
		else $error("write response not given one cycle after acceptance");
	COV_BLOCK: cover property (txValid && txLast && txReady && curFmt == FMT_BLOCK);
	COV_STREAM: cover property (txValid && txLast && txReady && curFmt == FMT_STREAM);
	COV_STALL: cover property (txValid && !txReady ##1 txValid && txReady);
	COV_ERR: cover property (s_q.err && !s_q.done);
endmodule : aspf_host_framer

/* File: test/aspf_fifo_sink.sv */
// Stand-in for the link transmit FIFO: takes quadlets, stalls on demand, counts whole packets.
// Assumes the framer drives txValid and txLast from registers clocked by clk_sys.
`timescale 1ns/1ps
module aspf_fifo_sink (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic stallOn,
	input wire logic txValid,
	input wire logic txLast,
	output logic txReady,
	output logic [7:0] pktCount
);
	logic [7:0] lfsr_q;
	// ----------------------------------------
	// Acceptance
	// ----------------------------------------
	// Stalls come from a free-running LFSR so that waits fall on every quadlet position.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			lfsr_q <= 8'hA5;
			txReady <= 1'b0;
			pktCount <= 8'h00;
		end else begin
			lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
			txReady <= !stallOn || lfsr_q[0];
			if (txValid && txReady && txLast) begin
				pktCount <= pktCount + 8'h01;
			end
		end
	end
endmodule : aspf_fifo_sink

/* File: test/async_tx_packet_format_tb.sv */
// Self-checking bench for the transmit packet framer over AXI4-Lite.
// Assumes the framer package and the FIFO stand-in are compiled first.
`timescale 1ns/1ps
module async_tx_packet_format_tb import aspf_pkg::*; ;
	logic clk_sys = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, stallOn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, txValid, txLast, txReady;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, txData, st;
	logic [7:0] pktCount;
	logic [32:0] expQ[$];
	logic [32:0] e;
	logic [3:0] rcs[5] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7};
	int mismatches = 0, checked = 0, seed = 96859, pkts = 0;
	always #4 clk_sys = ~clk_sys;
	aspf_host_framer aspf_host_framer_inst (.clk_sys, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .txData, .txValid, .txLast, .txReady);
	aspf_fifo_sink aspf_fifo_sink_inst (.clk_sys, .resetn, .stallOn, .txValid, .txLast, .txReady, .pktCount);
	// ----------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task report_and_stop;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// axw and axr each start by letting one edge pass, so no strobe is raised in the step that lowered it.
	// Bus waits carry no limit of their own; the watchdog ends a bus that never answers.
	task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk_sys); while (awready !== 1'b1);
		check("wready", {31'h0, wready}, 32'h1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk_sys); while (bvalid !== 1'b1);
		check("bresp", {30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
	endtask : axw
	task automatic axr(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_sys); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axr
	task automatic send(logic [3:0] tc, logic [1:0] spd, logic [3:0] pr, logic [3:0] rc, logic [15:0] len,
		logic ok);
		logic [31:0] dst, olo, qd, strm, w;
		logic [5:0] tl;
		logic [15:0] ext;
		logic [1:0] r;
		logic rsp;
		logic [32:0] q[$];
		int nw, n;
		dst = $random(seed);
		olo = $random(seed) & 32'hFFFFFFFC;
		qd = $random(seed);
		strm = $random(seed) & 32'h000F3F03;
		tl = 6'($random(seed));
		ext = 16'($random(seed));
		rsp = tc inside {TC_WRSP, TC_RRSPQ, TC_RRSPB, TC_LRSP};
		axw(REG_CFG, {4'h0, rc, 2'h0, tl, 4'h0, pr, 2'h0, spd, tc}, RESP_OKAY);
		axw(REG_DEST, dst, RESP_OKAY);
		axw(REG_OFFLO, olo, RESP_OKAY);
		axw(REG_LEN, {ext, len}, RESP_OKAY);
		axw(REG_QDATA, qd, RESP_OKAY);
		axw(REG_STREAM, strm, RESP_OKAY);
		q.push_back({1'b0, 14'h0, spd, tl, RETRY_X, tc, pr});
		if (tc == TC_STREAM) begin
			q.push_back({1'b0, len, strm[1:0], strm[13:8], tc, strm[19:16]});
		end else if (tc != TC_UNFMT) begin
			q.push_back({1'b0, dst[31:16], rsp ? {rc, 12'h0} : dst[15:0]});
			q.push_back({1'b0, rsp ? 32'h0 : olo});
			if (tc == TC_WRQ || tc == TC_RRSPQ) q.push_back({1'b0, qd});
			else if (!(tc inside {TC_RDQ, TC_WRSP})) q.push_back({1'b0, len, (tc == TC_LOCK || tc == TC_LRSP) ? ext : 16'h0});
		end
		nw = (tc inside {TC_WRB, TC_RRSPB, TC_LOCK, TC_LRSP, TC_STREAM, TC_UNFMT}) ? (len + 3) / 4 : 0;
		if (nw > 16) nw = 16;
		for (int i = 0; i < nw; i++) begin
			w = $random(seed);
			axw(REG_BUF + 8'(4 * i), w, RESP_OKAY);
			if (i == nw - 1 && len[1:0] != 2'h0) w = w & (32'hFFFFFFFF << (32 - 8 * len[1:0]));
			q.push_back({1'b0, w});
		end
		if (ok) begin
			q[$][32] = 1'b1;
			expQ = {expQ, q};
			pkts++;
		end
		axw(REG_CTRL, 32'h1, RESP_OKAY);
		n = 0;
		do axr(REG_STATUS, st, r); while (st[0] === 1'b1 && ++n < 200);
		check("status", {30'h0, st[2:1]}, {30'h0, !ok, ok});
		check("pending", expQ.size(), 32'h0);
	endtask : send
	// ----------------------------------------
	// Monitor, stimulus and watchdog
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (resetn === 1'b1 && txValid === 1'b1 && txReady === 1'b1) begin
			if (expQ.size() == 0) begin
				check("unexpected", 32'h1, 32'h0);
			end else begin
				e = expQ.pop_front();
				check("txData", txData, e[31:0]);
				check("txLast", {31'h0, txLast}, {31'h0, e[32]});
			end
		end
	end
	initial begin
		logic [1:0] r;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		axr(REG_STATUS, st, r);
		check("statusReset", st, 32'h0);
		axw(8'h30, 32'h5A5A5A5A, RESP_SLVERR);
		axr(8'h24, st, r);
		check("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
		check("rdata", st, 32'h0);
		for (int s = 0; s < 3; s++) send(TC_WRQ, s[1:0], 4'h0, 4'h0, 16'h4, 1'b1);
		send(TC_RDQ, 2'h1, 4'h0, 4'h0, 16'h0, 1'b1);
		foreach (rcs[i]) send(TC_WRSP, 2'h0, {3'h0, i[0]}, rcs[i], 16'h0, 1'b1);
		send(TC_RRSPQ, 2'h2, 4'h1, 4'h0, 16'h4, 1'b1);
		stallOn <= 1'b1;
		send(TC_WRB, 2'h1, 4'h0, 4'h0, 16'h5, 1'b1);
		send(TC_WRB, 2'h0, 4'h0, 4'h0, 16'h0, 1'b1);
		send(TC_RDB, 2'h2, 4'h0, 4'h0, 16'h200, 1'b1);
		send(TC_RRSPB, 2'h0, 4'h1, 4'h0, MAX_LEN, 1'b1);
		send(TC_LOCK, 2'h1, 4'h0, 4'h0, 16'h8, 1'b1);
		send(TC_LRSP, 2'h0, 4'h0, 4'h4, 16'h6, 1'b1);
		send(TC_STREAM, 2'h2, 4'h0, 4'h0, 16'h7, 1'b1);
		send(TC_STREAM, 2'h0, 4'h0, 4'h0, 16'h0, 1'b1);
		send(TC_UNFMT, 2'h0, 4'h0, 4'h0, 16'h8, 1'b1);
		send(TC_UNFMT, 2'h1, 4'h0, 4'h0, 16'h0, 1'b1);
		send(TC_WRQ, SPD_UNDEF, 4'h0, 4'h0, 16'h4, 1'b0);
		send(TC_WRSP, 2'h0, 4'h0, 4'h1, 16'h0, 1'b0);
		send(TC_WRSP, 2'h0, 4'h2, 4'h0, 16'h0, 1'b0);
		send(TC_WRB, 2'h0, 4'h0, 4'h0, 16'h44, 1'b0);
		send(4'h3, 2'h0, 4'h0, 4'h0, 16'h0, 1'b0);
		check("pktCount", {24'h0, pktCount}, pkts);
		report_and_stop();
	end
	initial begin
		#(8 * 40000);
		mismatches++;
		report_and_stop();
	end
endmodule : async_tx_packet_format_tb
